// File: inc/rotate_map.svh
/*
 * Opcode fields, bit positions, reset values and access bank split for the rotate datapath.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ROTATE_MAP_SVH
`define ROTATE_MAP_SVH

// Rotate opcode in instruction bits 15:10; d and a follow below it
`define RRC_OPC_HI      6'h0C
// Fill-ones opcode: upper seven bits, [0] is a fixed 0, not a destination bit
`define FILL_OPC_HI     7'h34
// Bit positions inside the 16-bit instruction word
`define INS_D_BIT       9
`define INS_A_BIT       8
`define INS_F_MSB       7
// Reset values
`define WREG_RST        8'h00
`define BANK_RST        4'h0
// Access bank split: low file addresses map to bank 0, the rest to bank 15
`define ACC_SPLIT       8'h80
`define ACC_LO_BANK     4'h0
`define ACC_HI_BANK     4'hF
`define FILL_VALUE      8'hFF

`endif

// File: inc/rotate_pkg.sv
/*
 * Types shared by the rotate datapath, its data memory model and the bench.
 * Assumes the map header supplies all numeric constants.
 */
package rotate_pkg;

    // Quarter phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;

    // Decoded operation
    typedef enum logic [2:0] {
        OP_NONE = 3'b001,
        OP_RRC  = 3'b010,
        OP_FILL = 3'b100
    } op_t;

    // Status flags touched by the rotate
    typedef struct packed {
        logic carry;
        logic neg;
        logic zero;
    } flags_t;

    // Data memory request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        we;
    } mem_req_t;

endpackage

// File: logic/bank_addr.sv
/*
 * Forms the 12-bit data address from the file field and bank choice.
 * Assumes the bank pointer is stable for the whole instruction cycle.
 */
`timescale 1ns/1ns
`include "rotate_map.svh"

module bank_addr (
    // Operand fields
    input  wire logic       use_bank_ptr,
    input  wire logic [7:0] file_addr,
    input  wire logic [3:0] bank_ptr,
    // Result
    output logic      [11:0] full_addr
);

    // Access bank splits into low bank 0 and top of bank 15
    always_comb begin
        if (use_bank_ptr) begin
            full_addr = {bank_ptr, file_addr};
        end else if (file_addr < `ACC_SPLIT) begin
            full_addr = {`ACC_LO_BANK, file_addr};
        end else begin
            full_addr = {`ACC_HI_BANK, file_addr};
        end
    end

endmodule // bank_addr

// File: logic/rotate_right_carry_datapath.sv
/*
 * Rotate-right-through-carry and fill-ones execution over four quarters.
 * Assumes a combinational-read data memory: read data valid in the same
 * phase the address is presented, one instruction word held for the cycle.
 */
// Functional notes
// - Shift operand right one; old carry enters bit 7, bit 0 to carry
// - Destination bit 0 writes result to working register only
// - Destination bit 1 writes result back to source register
// - Access bit 0 uses fixed access bank, ignoring bank pointer
// - Access bit 1 forms address from bank pointer register
// - Decode 0011 00da ffffffff; update only carry, negative, zero
// - One cycle: decode Q1, read Q2, process Q3, write Q4
`timescale 1ns/1ns
`include "rotate_map.svh"

module rotate_right_carry_datapath (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // Instruction and core state
    input  wire logic [15:0]          instr,
    input  wire logic [3:0]           bank_pointer_register,
    input  wire logic [7:0]           mem_rdata,
    input  wire rotate_pkg::flags_t   flags_in,
    // Data memory port
    output rotate_pkg::mem_req_t      mem_req,
    // Working register and flags
    output logic [7:0]                wreg,
    output rotate_pkg::flags_t        flags,
    output logic                      flags_we,
    output rotate_pkg::phase_t        phase
);

    rotate_pkg::phase_t   phase_r, phase_nxt;
    rotate_pkg::op_t      op_r, op_nxt;
    logic                 dest_r, dest_nxt;
    logic [7:0]           opnd_r, opnd_nxt;
    logic [7:0]           res_r, res_nxt;
    rotate_pkg::flags_t   fl_r, fl_nxt;
    rotate_pkg::mem_req_t req_r, req_nxt;
    logic [7:0]           wreg_r, wreg_nxt;
    logic                 fwe_r, fwe_nxt;
    logic [11:0]          dec_addr;

    // Bank selection
    bank_addr u_bank (
        .use_bank_ptr (instr[`INS_A_BIT]),
        .file_addr    (instr[`INS_F_MSB:0]),
        .bank_ptr     (bank_pointer_register),
        .full_addr    (dec_addr)
    );

    // Phase sequencer and execution
    always_comb begin
        phase_nxt = phase_r;
        op_nxt    = op_r;
        dest_nxt  = dest_r;
        opnd_nxt  = opnd_r;
        res_nxt   = res_r;
        fl_nxt    = fl_r;
        req_nxt   = req_r;
        wreg_nxt  = wreg_r;
        fwe_nxt   = 1'b0;
        req_nxt.we = 1'b0;
        case (phase_r)
            rotate_pkg::PH_Q1: begin
                phase_nxt = rotate_pkg::PH_Q2;
                // Only the documented encodings execute
                if (instr[15:10] == `RRC_OPC_HI) begin
                    op_nxt = rotate_pkg::OP_RRC;
                end else if (instr[15:9] == `FILL_OPC_HI) begin
                    op_nxt = rotate_pkg::OP_FILL;
                end else begin
                    op_nxt = rotate_pkg::OP_NONE;
                end
                dest_nxt     = instr[`INS_D_BIT];
                req_nxt.addr = dec_addr;
            end
            rotate_pkg::PH_Q2: begin
                phase_nxt = rotate_pkg::PH_Q3;
                opnd_nxt  = mem_rdata;
            end
            rotate_pkg::PH_Q3: begin
                phase_nxt = rotate_pkg::PH_Q4;
                if (op_r == rotate_pkg::OP_FILL) begin
                    res_nxt = `FILL_VALUE;
                end else begin
                    res_nxt = {flags_in.carry, opnd_r[7:1]};
                end
            end
            rotate_pkg::PH_Q4: begin
                phase_nxt = rotate_pkg::PH_Q1;
                if (op_r == rotate_pkg::OP_RRC) begin
                    fl_nxt.carry = opnd_r[0];
                    fl_nxt.neg   = res_r[7];
                    fl_nxt.zero  = (res_r == 8'h00);
                    fwe_nxt      = 1'b1;
                    if (dest_r) begin
                        req_nxt.we    = 1'b1;
                        req_nxt.wdata = res_r;
                    end else begin
                        wreg_nxt = res_r;
                    end
                end else if (op_r == rotate_pkg::OP_FILL) begin
                    req_nxt.we    = 1'b1;
                    req_nxt.wdata = res_r;
                end
            end
            default: begin
                phase_nxt = rotate_pkg::PH_Q1;
            end
        endcase
    end

    // Register the state
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            phase_r <= rotate_pkg::PH_Q1;
            op_r    <= rotate_pkg::OP_NONE;
            dest_r  <= 1'b0;
            opnd_r  <= 8'h00;
            res_r   <= 8'h00;
            fl_r    <= 3'b000;
            req_r   <= '0;
            wreg_r  <= `WREG_RST;
            fwe_r   <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            op_r    <= op_nxt;
            dest_r  <= dest_nxt;
            opnd_r  <= opnd_nxt;
            res_r   <= res_nxt;
            fl_r    <= fl_nxt;
            req_r   <= req_nxt;
            wreg_r  <= wreg_nxt;
            fwe_r   <= fwe_nxt;
        end
    end

    // Outputs straight from flops
    assign mem_req  = req_r;
    assign wreg     = wreg_r;
    assign flags    = fl_r;
    assign flags_we = fwe_r;
    assign phase    = phase_r;

    // Checks: phase ring and write timing
    phase_ring_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q1 |=> phase_r == rotate_pkg::PH_Q2
        ##1 phase_r == rotate_pkg::PH_Q3 ##1 phase_r == rotate_pkg::PH_Q4)
        else $error("phase order broken");
    write_slot_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        req_r.we || fwe_r |-> phase_r == rotate_pkg::PH_Q1
        && $past(phase_r) == rotate_pkg::PH_Q4)
        else $error("write outside fourth quarter");

    // Checks: datapath values
    rot_value_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q3 && op_r == rotate_pkg::OP_RRC |=>
        res_r == {$past(flags_in.carry), $past(opnd_r[7:1])})
        else $error("rotate result wrong");
    carry_out_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        fwe_r |-> fl_r.carry == $past(opnd_r[0]))
        else $error("carry not old bit 0");

    // Checks: destination choice
    wreg_dest_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q4 && op_r == rotate_pkg::OP_RRC
        && !dest_r |=> wreg_r == $past(res_r) && !req_r.we)
        else $error("working reg dest wrong");
    // Working register may only move on the edge that ends Q4
    wreg_hold_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r != rotate_pkg::PH_Q1 |-> $stable(wreg_r))
        else $error("working reg moved mid-cycle");
    file_dest_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q4 && op_r == rotate_pkg::OP_RRC
        && dest_r |=> req_r.we && req_r.wdata == $past(res_r)
        && $stable(wreg_r))
        else $error("file dest wrong");

    // Checks: bank selection and file field
    access_bank_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q1 && !instr[`INS_A_BIT]
        && instr[7:0] < `ACC_SPLIT |=> req_r.addr[11:8] == `ACC_LO_BANK)
        else $error("access bank ignored");
    access_high_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q1 && !instr[`INS_A_BIT]
        && instr[7:0] >= `ACC_SPLIT |=> req_r.addr[11:8] == `ACC_HI_BANK)
        else $error("access bank top half wrong");
    bank_ptr_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q1 && instr[`INS_A_BIT] |=>
        req_r.addr[11:8] == $past(bank_pointer_register))
        else $error("bank pointer not used");
    file_field_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q1 |=>
        req_r.addr[7:0] == $past(instr[7:0]))
        else $error("file field not addressed");

    // Checks: flags and refused encodings
    zero_flag_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        fwe_r |-> fl_r.zero == (wreg_r == 8'h00 && !req_r.we
        || req_r.we && req_r.wdata == 8'h00))
        else $error("zero flag wrong");
    neg_flag_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        fwe_r |-> fl_r.neg == (req_r.we ? req_r.wdata[7] : wreg_r[7]))
        else $error("negative flag wrong");
    // Unknown words must leave memory, flags and W alone
    refused_op_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q4 && op_r == rotate_pkg::OP_NONE
        |=> !req_r.we && !fwe_r && $stable(wreg_r))
        else $error("refused opcode had effect");
    fill_flags_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        phase_r == rotate_pkg::PH_Q4 && op_r == rotate_pkg::OP_FILL |=>
        !fwe_r && req_r.we && req_r.wdata == `FILL_VALUE && $stable(fl_r))
        else $error("fill wrong");

endmodule // rotate_right_carry_datapath

// File: dv/data_mem_model.sv
/*
 * Data memory behind the rotate datapath's memory port.
 * Assumes one clock; the bench preloads cells by hierarchical write.
 */
`timescale 1ns/1ns

module data_mem_model (
    // Clock
    input  wire logic                 core_clk,
    // Request and read data
    input  wire rotate_pkg::mem_req_t mem_req,
    output logic [7:0]                mem_rdata
);
    logic [7:0] mem [4096];

    // Combinational read on the registered address, so Q2 sees it at once
    assign mem_rdata = mem[mem_req.addr];

    // Write lands on the edge that ends the request pulse
    always @(posedge core_clk) begin
        if (mem_req.we) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
    end
endmodule // data_mem_model

// File: dv/tb.sv
/*
 * Self-checking bench for the rotate datapath.
 * Assumes the data memory model answers the port combinationally.
 */
`timescale 1ns/1ns

module tb;
    logic                 core_clk, nrst, g_fwe, g_we, g_ph;
    logic [15:0]          instr;
    logic [3:0]           bank_pointer_register;
    logic [7:0]           mem_rdata, wreg, g_wreg, g_wdata;
    logic [11:0]          g_addr;
    rotate_pkg::flags_t   flags_in, flags, g_flags;
    rotate_pkg::mem_req_t mem_req;
    rotate_pkg::phase_t   phase;
    logic                 flags_we;
    int                   fails, n_compared;

    rotate_right_carry_datapath rotate_right_carry_datapath_i (
        .core_clk(core_clk), .nrst(nrst), .instr(instr),
        .bank_pointer_register(bank_pointer_register),
        .mem_rdata(mem_rdata), .flags_in(flags_in), .mem_req(mem_req),
        .wreg(wreg), .flags(flags), .flags_we(flags_we), .phase(phase));
    data_mem_model data_mem_model_i (
        .core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One instruction launched at a Q1 start; a no-op follows so the
    // held word is never decoded twice
    task automatic exec(input logic [15:0] ins, input logic [3:0] bank,
                        input logic c);
        int k;
        k = 0;
        @(negedge core_clk);
        while (phase !== rotate_pkg::PH_Q4) begin
            k++;
            if (k > 8) begin
                fails++;
                close_out();
            end
            @(negedge core_clk);
        end
        @(posedge core_clk);
        instr <= ins;
        bank_pointer_register <= bank;
        flags_in <= rotate_pkg::flags_t'({c, 2'b00});
        g_ph = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            if (phase !== rotate_pkg::phase_t'(4'b0001 << i)) begin
                g_ph = 1'b0;
            end
            if (i == 1) begin
                g_addr = mem_req.addr;
            end
        end
        @(posedge core_clk);
        instr <= 16'h0000;
        @(negedge core_clk);
        g_we = mem_req.we;
        g_wdata = mem_req.wdata;
        g_fwe = flags_we;
        g_flags = flags;
        g_wreg = wreg;
        @(posedge core_clk);
        #1;
    endtask

    // Result to W, banked operand, carry clear
    task automatic sc_dest_w();
        data_mem_model_i.mem[12'h521] = 8'hE6;
        exec(16'h3121, 4'h5, 1'b0);
        chk(g_ph, 1'b1);
        chk(g_addr, 12'h521);
        chk(g_wreg, 8'h73);
        chk({g_we, data_mem_model_i.mem[12'h521]}, 9'h0E6);
        chk({g_fwe, g_flags}, 4'h8);
    endtask

    // Back to source, low access bank, zero result, bank pointer ignored
    task automatic sc_acc_low();
        data_mem_model_i.mem[12'h010] = 8'h01;
        exec(16'h3210, 4'h5, 1'b0);
        chk(g_addr, 12'h010);
        chk({g_we, g_wdata}, 9'h100);
        chk(data_mem_model_i.mem[12'h010], 8'h00);
        chk({g_fwe, g_flags}, 4'hD);
        chk(g_wreg, 8'h73);
    endtask

    // High access bank, carry set enters bit 7
    task automatic sc_acc_high();
        data_mem_model_i.mem[12'hF90] = 8'h02;
        exec(16'h3290, 4'h5, 1'b1);
        chk(g_addr, 12'hF90);
        chk(data_mem_model_i.mem[12'hF90], 8'h81);
        chk({g_fwe, g_flags}, 4'hA);
    endtask

    // Fill-ones, banked, flags untouched
    task automatic sc_fill();
        data_mem_model_i.mem[12'h344] = 8'h12;
        exec(16'h6944, 4'h3, 1'b1);
        chk(g_addr, 12'h344);
        chk(data_mem_model_i.mem[12'h344], 8'hFF);
        chk(g_fwe, 1'b0);
        chk({g_we, g_wdata}, 9'h1FF);
        chk(g_flags, 3'h2);
    endtask

    // Unhandled opcode does nothing
    task automatic sc_refused();
        exec(16'h4521, 4'h5, 1'b1);
        chk({g_we, g_fwe, g_wreg}, 10'h073);
        chk(data_mem_model_i.mem[12'h521], 8'hE6);
    endtask

    // Reset in mid-run clears state, then a rotate runs cleanly again
    task automatic sc_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        chk(phase, 12'h001);
        chk({flags_we, flags, wreg}, 12'h000);
        chk(mem_req.addr, 12'h000);
        chk({mem_req.we, mem_req.wdata}, 9'h000);
        @(posedge core_clk);
        nrst <= 1'b1;
        exec(16'h3121, 4'h5, 1'b1);
        chk(g_wreg, 8'hF3);
        chk({g_fwe, g_flags}, 4'hA);
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0;
        instr = 16'h0000;
        bank_pointer_register = 4'h0;
        flags_in = '0;
        fails = 0;
        n_compared = 0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        sc_dest_w();
        sc_acc_low();
        sc_acc_high();
        sc_fill();
        sc_refused();
        sc_reset();
        close_out();
    end
endmodule // tb
